/* File: serial_port_cfg.svh */
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// Register indices, byte address is four times the index
`define CTRL_IDX          8'h98
`define BUF_IDX           8'h99
`define PWR_IDX           8'h87
`define SLV_ADDR_IDX      8'ha9
`define SLV_MASK_IDX      8'hb9

// Reset values
`define SLV_ADDR_RST      8'h00
`define SLV_MASK_RST      8'h00

// Serial control register fields
`define CTRL_SHARED_BIT   7
`define CTRL_MODE_HI_BIT  6
`define CTRL_MP_BIT       5
`define CTRL_RXEN_BIT     4
`define CTRL_TX9_BIT      3
`define CTRL_RX9_BIT      2
`define CTRL_TXDONE_BIT   1
`define CTRL_RXDONE_BIT   0

// Power control register fields
`define PWR_DBL_BIT       7
`define PWR_FESEL_BIT     6

// Timing counts in clocks, oversampling ticks and bits
`define SHIFT_DIV_SLOW    4'hc
`define SHIFT_DIV_FAST    4'h4
`define OSC_TICK_SLOW     2'h3
`define OSC_TICK_FAST     2'h1
`define OVS_LAST          4'hf
`define SAMPLE_FIRST      4'h8
`define SAMPLE_MID        4'h9
`define SAMPLE_LAST       4'ha
`define SHIFT_BITS        4'h8
`define FRAME_BITS_SHORT  4'h9
`define FRAME_BITS_LONG   4'ha

`endif

/* File: serial_port_pkg.sv */
`default_nettype none
package serial_port_pkg;
	typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC8, MODE_ASYNC9_OSC, MODE_ASYNC9_TMR} mode_t;
	typedef enum logic [1:0] {ARX_IDLE, ARX_FRAME} arx_state_t;
	typedef enum logic [1:0] {ATX_IDLE, ATX_FRAME} atx_state_t;
	typedef enum logic [1:0] {SH_IDLE, SH_OUT, SH_IN} sh_state_t;
endpackage
`default_nettype wire

/* File: addr_match_if.sv */
`default_nettype none
interface addr_match_if;
	logic [7:0] rxByte;
	logic [7:0] slvAddr;
	logic [7:0] slvMask;
	logic       hit;
	modport requester (output rxByte, output slvAddr, output slvMask, input hit);
	modport matcher   (input rxByte, input slvAddr, input slvMask, output hit);
endinterface
`default_nettype wire

/* File: addr_match.sv */
`default_nettype none
module addr_match (
	addr_match_if.matcher m
);
	logic [7:0] bcast;
	logic       givenHit;
	logic       bcastHit;

	// Masked compare, zero mask bits are don't care
	assign givenHit = ((m.rxByte ^ m.slvAddr) & m.slvMask) == 8'h00;
	// Broadcast pattern, zero bits are don't care
	assign bcast    = m.slvAddr | m.slvMask;
	assign bcastHit = (m.rxByte & bcast) == bcast;
	assign m.hit    = givenHit | bcastHit;
endmodule
`default_nettype wire

/* File: serial_port.sv */
`default_nettype none
`include "serial_port_cfg.svh"
// How it works
// - Mode 3 equals mode 2, timer baud
// - Buffer write starts transmission, all modes
// - Shift mode receives when flag clear, enabled
// - Async receive starts on start bit
// - Mode 2: 11 bits, 32/64 clocks
// - Modes 1 and 3 use timer overflow
// - Missing stop bit raises framing error
// - Control bit 7 shared, select chooses
// - Framing error set by hardware, software clears
// - Multiprocessor 9-bit modes need address match
// - Multiprocessor off: every frame flags while receive flag clear
// - Mode 1 multiprocessor: stop and match
// - Given address is masked compare
// - Broadcast is address OR mask
// - Address registers at A9h/B9h, reset zero
// - Majority of samples 8, 9, 10
// - Ninth bit sent and received
// - Load only if flag clear, conditions met
// - Shift rate quarter or twelfth clock
module serial_port (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timerOverflow,
	input  wire logic        rxdIn,
	output logic             rxdOut,
	output logic             rxdOe,
	output logic             txdOut,
	output logic             serialIrq
);
	logic                     rstMeta_r;
	logic                     rstN;
	logic                     pready_r;
	logic [31:0]              prdata_r;
	logic                     pslverr_r;
	logic                     modeLow_r;
	logic                     modeHigh_r;
	logic                     mpEnable_r;
	logic                     rxEnable_r;
	logic                     txNinth_r;
	logic                     rxNinth_r;
	logic                     txDone_r;
	logic                     rxDone_r;
	logic                     frameErr_r;
	logic                     feSelect_r;
	logic                     baudDbl_r;
	logic [7:0]               slvAddr_r;
	logic [7:0]               slvMask_r;
	logic [7:0]               rxBuf_r;
	logic                     tick_r;
	logic [1:0]               oscCnt_r;
	logic                     ovfHalf_r;
	serial_port_pkg::atx_state_t atx_r;
	logic [3:0]               atxCnt_r;
	logic [10:0]              atxShift_r;
	logic [3:0]               atxLeft_r;
	logic                     atxLine_r;
	serial_port_pkg::arx_state_t arx_r;
	logic [3:0]               arxCnt_r;
	logic [3:0]               arxIdx_r;
	logic [1:0]               arxSamp_r;
	logic [9:0]               arxShift_r;
	logic                     rxdPrev_r;
	serial_port_pkg::sh_state_t sh_r;
	logic [3:0]               shPhase_r;
	logic [3:0]               shBits_r;
	logic [7:0]               shData_r;
	logic                     shClk_r;
	logic                     shOut_r;
	logic                     evTxDone_r;
	logic                     evRxLoad_r;
	logic                     evFe_r;
	logic [7:0]               evByte_r;
	logic                     evNinth_r;
	logic                     txdOut_r;
	logic                     rxdOut_r;
	logic                     rxdOe_r;
	logic                     irq_r;
	serial_port_pkg::mode_t   mode;
	logic                     apbDone;
	logic                     apbWr;
	logic [7:0]               idx;
	logic                     idxOk;
	logic                     hit;
	logic [31:0]              rdMux;
	logic                     bufWrite;
	logic                     ctrlWrite;
	logic [3:0]               shDiv;
	logic [3:0]               shFall;
	logic [3:0]               shRise;
	logic                     vote;
	logic                     frameEnd;
	logic                     stopBit;
	logic                     ninthBit;
	logic                     acceptOk;
	logic [7:0]               frameByte;

	addr_match_if am ();

	addr_match u_match (
		.m (am.matcher)
	);

	// Reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_r <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN      <= rstMeta_r;
		end
	end

	assign mode      = serial_port_pkg::mode_t'({modeHigh_r, modeLow_r});
	assign idx       = paddr[9:2];
	assign idxOk     = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign apbDone   = psel & penable & pready_r;
	assign apbWr     = apbDone & pwrite & hit;
	assign bufWrite  = apbWr && (idx == `BUF_IDX);
	assign ctrlWrite = apbWr && (idx == `CTRL_IDX);

	// Address decode and read data
	always_comb begin
		hit   = idxOk;
		rdMux = 32'h0000_0000;
		if (!idxOk) begin
			hit = 1'b0;
		end else if (idx == `CTRL_IDX) begin
			rdMux[7:0] = {feSelect_r ? frameErr_r : modeLow_r, modeHigh_r, mpEnable_r,
				rxEnable_r, txNinth_r, rxNinth_r, txDone_r, rxDone_r};
		end else if (idx == `BUF_IDX) begin
			rdMux[7:0] = rxBuf_r;
		end else if (idx == `PWR_IDX) begin
			rdMux[`PWR_DBL_BIT]   = baudDbl_r;
			rdMux[`PWR_FESEL_BIT] = feSelect_r;
		end else if (idx == `SLV_ADDR_IDX) begin
			rdMux[7:0] = slvAddr_r;
		end else if (idx == `SLV_MASK_IDX) begin
			rdMux[7:0] = slvMask_r;
		end else begin
			hit = 1'b0;
		end
	end

	// APB answer one cycle into the access phase
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel & penable & ~pready_r;
			prdata_r  <= (psel & penable & ~pready_r & ~pwrite) ? rdMux : 32'h0000_0000;
			pslverr_r <= psel & penable & ~pready_r & ~hit;
		end
	end

	// Control fields and power control
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			modeLow_r  <= 1'b0;
			modeHigh_r <= 1'b0;
			mpEnable_r <= 1'b0;
			rxEnable_r <= 1'b0;
			txNinth_r  <= 1'b0;
			feSelect_r <= 1'b0;
			baudDbl_r  <= 1'b0;
		end else if (apbWr) begin
			if (idx == `CTRL_IDX) begin
				if (!feSelect_r) begin
					modeLow_r <= pwdata[`CTRL_SHARED_BIT];
				end
				modeHigh_r <= pwdata[`CTRL_MODE_HI_BIT];
				mpEnable_r <= pwdata[`CTRL_MP_BIT];
				rxEnable_r <= pwdata[`CTRL_RXEN_BIT];
				txNinth_r  <= pwdata[`CTRL_TX9_BIT];
			end else if (idx == `PWR_IDX) begin
				baudDbl_r  <= pwdata[`PWR_DBL_BIT];
				feSelect_r <= pwdata[`PWR_FESEL_BIT];
			end
		end
	end

	// Address registers
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			slvAddr_r <= `SLV_ADDR_RST;
			slvMask_r <= `SLV_MASK_RST;
		end else if (apbWr && (idx == `SLV_ADDR_IDX)) begin
			slvAddr_r <= pwdata[7:0];
		end else if (apbWr && (idx == `SLV_MASK_IDX)) begin
			slvMask_r <= pwdata[7:0];
		end
	end

	// Hardware sets win over software writes
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			txDone_r   <= 1'b0;
			rxDone_r   <= 1'b0;
			rxNinth_r  <= 1'b0;
			frameErr_r <= 1'b0;
			rxBuf_r    <= 8'h00;
		end else begin
			if (evTxDone_r) begin
				txDone_r <= 1'b1;
			end else if (ctrlWrite) begin
				txDone_r <= pwdata[`CTRL_TXDONE_BIT];
			end
			if (evRxLoad_r) begin
				rxDone_r  <= 1'b1;
				rxBuf_r   <= evByte_r;
				rxNinth_r <= evNinth_r;
			end else if (ctrlWrite) begin
				rxDone_r  <= pwdata[`CTRL_RXDONE_BIT];
				rxNinth_r <= pwdata[`CTRL_RX9_BIT];
			end
			if (evFe_r) begin
				frameErr_r <= 1'b1;
			end else if (ctrlWrite && feSelect_r) begin
				frameErr_r <= pwdata[`CTRL_SHARED_BIT];
			end
		end
	end

	// Oversampling tick, sixteen per bit
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			tick_r    <= 1'b0;
			oscCnt_r  <= 2'h0;
			ovfHalf_r <= 1'b0;
		end else if (mode == serial_port_pkg::MODE_ASYNC9_OSC) begin
			oscCnt_r  <= (oscCnt_r == 2'h0) ? (baudDbl_r ? `OSC_TICK_FAST : `OSC_TICK_SLOW)
				: oscCnt_r - 2'h1;
			tick_r    <= (oscCnt_r == 2'h0);
		end else begin
			oscCnt_r  <= 2'h0;
			ovfHalf_r <= timerOverflow ? ~ovfHalf_r : ovfHalf_r;
			tick_r    <= timerOverflow & (baudDbl_r | ovfHalf_r);
		end
	end

	// Async transmitter on free-running divide-by-16
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			atx_r      <= serial_port_pkg::ATX_IDLE;
			atxCnt_r   <= 4'h0;
			atxShift_r <= 11'h7ff;
			atxLeft_r  <= 4'h0;
			atxLine_r  <= 1'b1;
			evTxDone_r <= 1'b0;
		end else begin
			evTxDone_r <= 1'b0;
			if (tick_r) begin
				atxCnt_r <= atxCnt_r + 4'h1;
			end
			case (atx_r)
				serial_port_pkg::ATX_IDLE: begin
					if (bufWrite && (mode != serial_port_pkg::MODE_SHIFT)) begin
						atx_r      <= serial_port_pkg::ATX_FRAME;
						atxShift_r <= {1'b1, (mode == serial_port_pkg::MODE_ASYNC8) ? 1'b1
							: txNinth_r, pwdata[7:0], 1'b0};
						atxLeft_r  <= (mode == serial_port_pkg::MODE_ASYNC8) ?
							`FRAME_BITS_SHORT : `FRAME_BITS_LONG;
					end
				end
				serial_port_pkg::ATX_FRAME: begin
					if (tick_r && (atxCnt_r == `OVS_LAST)) begin
						atxLine_r  <= atxShift_r[0];
						atxShift_r <= {1'b1, atxShift_r[10:1]};
						atxLeft_r  <= atxLeft_r - 4'h1;
						if (atxLeft_r == 4'h0) begin
							atx_r      <= serial_port_pkg::ATX_IDLE;
							evTxDone_r <= 1'b1;
						end
					end
				end
				default: atx_r <= serial_port_pkg::ATX_IDLE;
			endcase
		end
	end

	assign vote      = (arxSamp_r[1] & arxSamp_r[0]) | (rxdIn & (arxSamp_r[1] | arxSamp_r[0]));
	assign frameEnd  = (arxIdx_r == ((mode == serial_port_pkg::MODE_ASYNC8) ?
		`FRAME_BITS_SHORT : `FRAME_BITS_LONG));
	assign stopBit   = vote;
	assign ninthBit  = (mode == serial_port_pkg::MODE_ASYNC8) ? vote : arxShift_r[9];
	assign frameByte = (mode == serial_port_pkg::MODE_ASYNC8) ? arxShift_r[9:2]
		: arxShift_r[8:1];
	assign am.rxByte  = frameByte;
	assign am.slvAddr = slvAddr_r;
	assign am.slvMask = slvMask_r;
	assign acceptOk  = ~rxDone_r & (~mpEnable_r | (ninthBit & stopBit & am.hit));

	// Async receiver
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			arx_r      <= serial_port_pkg::ARX_IDLE;
			arxCnt_r   <= 4'h0;
			arxIdx_r   <= 4'h0;
			arxSamp_r  <= 2'h0;
			arxShift_r <= 10'h000;
			rxdPrev_r  <= 1'b1;
			evFe_r     <= 1'b0;
		end else begin
			evFe_r <= 1'b0;
			if (tick_r) begin
				rxdPrev_r <= rxdIn;
			end
			case (arx_r)
				serial_port_pkg::ARX_IDLE: begin
					if (tick_r && rxdPrev_r && !rxdIn && rxEnable_r &&
						(mode != serial_port_pkg::MODE_SHIFT)) begin
						arx_r    <= serial_port_pkg::ARX_FRAME;
						arxCnt_r <= 4'h0;
						arxIdx_r <= 4'h0;
					end
				end
				serial_port_pkg::ARX_FRAME: begin
					if (tick_r) begin
						arxCnt_r <= arxCnt_r + 4'h1;
						if ((arxCnt_r == `SAMPLE_FIRST) || (arxCnt_r == `SAMPLE_MID)) begin
							arxSamp_r <= {arxSamp_r[0], rxdIn};
						end
						if (arxCnt_r == `SAMPLE_LAST) begin
							arxIdx_r <= arxIdx_r + 4'h1;
							if ((arxIdx_r == 4'h0) && vote) begin
								arx_r <= serial_port_pkg::ARX_IDLE;
							end else if (frameEnd) begin
								arx_r  <= serial_port_pkg::ARX_IDLE;
								evFe_r <= ~stopBit;
							end else if (arxIdx_r != 4'h0) begin
								arxShift_r <= {vote, arxShift_r[9:1]};
							end
						end
					end
				end
				default: arx_r <= serial_port_pkg::ARX_IDLE;
			endcase
		end
	end

	assign shDiv  = mpEnable_r ? `SHIFT_DIV_FAST : `SHIFT_DIV_SLOW;
	assign shFall = shDiv >> 2;
	assign shRise = shDiv - (shDiv >> 2);

	// Synchronous shift engine, clock out on transmit pin
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sh_r      <= serial_port_pkg::SH_IDLE;
			shPhase_r <= 4'h0;
			shBits_r  <= 4'h0;
			shData_r  <= 8'h00;
			shClk_r   <= 1'b1;
			shOut_r   <= 1'b1;
		end else begin
			case (sh_r)
				serial_port_pkg::SH_IDLE: begin
					shPhase_r <= 4'h0;
					shBits_r  <= 4'h0;
					shClk_r   <= 1'b1;
					if (bufWrite && (mode == serial_port_pkg::MODE_SHIFT)) begin
						sh_r     <= serial_port_pkg::SH_OUT;
						shData_r <= pwdata[7:0];
					end else if ((mode == serial_port_pkg::MODE_SHIFT) && rxEnable_r &&
						!rxDone_r && !evRxLoad_r) begin
						sh_r <= serial_port_pkg::SH_IN;
					end
				end
				serial_port_pkg::SH_OUT, serial_port_pkg::SH_IN: begin
					shPhase_r <= (shPhase_r == shDiv - 4'h1) ? 4'h0 : shPhase_r + 4'h1;
					if ((shPhase_r == 4'h0) && (sh_r == serial_port_pkg::SH_OUT)) begin
						shOut_r <= shData_r[0];
					end
					if (shPhase_r == shFall) begin
						shClk_r <= 1'b0;
					end
					if (shPhase_r == shRise) begin
						shClk_r  <= 1'b1;
						shData_r <= {rxdIn, shData_r[7:1]};
						shBits_r <= shBits_r + 4'h1;
					end
					if ((shPhase_r == shDiv - 4'h1) && (shBits_r == `SHIFT_BITS)) begin
						sh_r <= serial_port_pkg::SH_IDLE;
					end
				end
				default: sh_r <= serial_port_pkg::SH_IDLE;
			endcase
		end
	end

	// Receive completion events from shift and async engines
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			evRxLoad_r <= 1'b0;
			evByte_r   <= 8'h00;
			evNinth_r  <= 1'b0;
		end else begin
			evRxLoad_r <= 1'b0;
			if ((sh_r == serial_port_pkg::SH_IN) && (shPhase_r == shDiv - 4'h1) &&
				(shBits_r == `SHIFT_BITS)) begin
				evRxLoad_r <= 1'b1;
				evByte_r   <= shData_r;
				evNinth_r  <= rxNinth_r;
			end else if ((arx_r == serial_port_pkg::ARX_FRAME) && tick_r &&
				(arxCnt_r == `SAMPLE_LAST) && frameEnd && acceptOk) begin
				evRxLoad_r <= 1'b1;
				evByte_r   <= frameByte;
				evNinth_r  <= ninthBit;
			end
		end
	end

	// Pins and interrupt request
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			txdOut_r <= 1'b1;
			rxdOut_r <= 1'b1;
			rxdOe_r  <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			txdOut_r <= (mode == serial_port_pkg::MODE_SHIFT) ? shClk_r : atxLine_r;
			rxdOut_r <= shOut_r;
			rxdOe_r  <= (sh_r == serial_port_pkg::SH_OUT);
			irq_r    <= txDone_r | rxDone_r;
		end
	end

	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign txdOut    = txdOut_r;
	assign rxdOut    = rxdOut_r;
	assign rxdOe     = rxdOe_r;
	assign serialIrq = irq_r;
endmodule
`default_nettype wire

/* File: serial_port_assertions.sv */
`default_nettype none
`include "serial_port_cfg.svh"
module serial_port_assertions (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serialIrq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic mapped;
	// Byte addresses of the five registers
	assign mapped = paddr inside {12'h260, 12'h264, 12'h21c, 12'h2a4, 12'h2e4};
	ready_timing_a: assert property ($rose(penable) && psel |=> pready)
		else $error("answer missing in second access cycle");
	ready_access_a: assert property (pready |-> psel && penable && !$rose(penable))
		else $error("answer outside second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("answer held too long");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without answer or with data");
	misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access accepted");
	mapped_ok_a: assert property (pready && mapped |-> !pslverr)
		else $error("mapped register refused");
	irq_match_a: assert property (pready && !pwrite && paddr == 12'h260 |-> serialIrq == (prdata[1] | prdata[0]))
		else $error("interrupt differs from flags");
	cover property (pready && pwrite && paddr == 12'h264);
	cover property (pslverr);
	cover property (pready && !pwrite && paddr == 12'h260 && prdata[0]);
endmodule
bind serial_port serial_port_assertions u_chk (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serialIrq(serialIrq));
`default_nettype wire

/* File: serial_peer.sv */
`default_nettype none
module serial_peer #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic       clk,
	input  wire logic       txdOut,
	output logic            rxdIn,
	output logic            gotValid,
	output logic      [9:0] gotWord
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rxdIn = 1'b1;
		gotValid = 1'b0;
		gotWord = 10'h0;
	end
	// Whole frame, start bit first, then line back to idle high
	task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
		logic [10:0] f;
		f = {stop, ninth, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk) rxdIn <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
		@(posedge clk) rxdIn <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
	endtask
	// Frame decoder, sampled mid bit
	initial forever begin
		logic [9:0] w;
		@(negedge txdOut);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			w[i] = txdOut;
		end
		gotWord <= w;
		gotValid <= 1'b1;
		@(posedge clk) gotValid <= 1'b0;
	end
endmodule
`default_nettype wire

/* File: test_serial_port_frame_err_addr_match.sv */
`default_nettype none
module test_serial_port_frame_err_addr_match;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] CTRL = 12'h260, BUFA = 12'h264, PWR = 12'h21c;
	localparam logic [11:0] SADR = 12'h2a4, SMSK = 12'h2e4;
	localparam logic [9:0]  MP_TAB [5] = '{10'h3a0, 10'h1a2, 10'h3ff, 10'h0a0, 10'h3a5};
	logic        clk, nrst, psel, penable, pwrite, timerOverflow, rxdIn;
	logic        pready, pslverr, rxdOut, rxdOe, txdOut, serialIrq, gotValid, hit, n9, r9;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0]  gotWord;
	logic [7:0]  d, b;
	logic [32:0] rdQ[$], txQ[$];
	int          failures, totalChecks;
	integer      seed;
	serial_port u_serial_port (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timerOverflow(timerOverflow), .rxdIn(rxdIn), .rxdOut(rxdOut),
		.rxdOe(rxdOe), .txdOut(txdOut), .serialIrq(serialIrq));
	serial_peer u_serial_peer (.clk(clk), .txdOut(txdOut), .rxdIn(rxdIn),
		.gotValid(gotValid), .gotWord(gotWord));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) timerOverflow <= ~timerOverflow;
	task check(input logic [32:0] seen, input logic [32:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (failures == 0 && totalChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task timeout;
		check(33'h0, 33'h1);
		give_verdict();
	endtask
	// Results matched against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			if (rdQ.size() > 0) check({pslverr, prdata}, rdQ.pop_front());
			else check(33'h0, 33'h1);
		end
		if (gotValid === 1'b1) begin
			if (txQ.size() > 0) check({23'h0, gotWord}, txQ.pop_front());
			else check(33'h0, 33'h1);
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		if (!w) rdQ.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) timeout();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] v);
		apb(1'b1, a, {24'h0, v}, 33'h0);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0, {25'h0, e});
	endtask
	task tx(input logic [7:0] v, input logic ninth);
		int n;
		txQ.push_back({23'h0, 1'b1, ninth, v});
		wr(BUFA, v);
		n = 0;
		while (txQ.size() != 0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (txQ.size() != 0) timeout();
	endtask
	initial begin
		seed = 32'h229d6a34;
		failures = 0;
		totalChecks = 0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		timerOverflow = 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		rd(SADR, 8'h00);
		rd(SMSK, 8'h00);
		apb(1'b0, 12'h3fc, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 12'h2a5, 32'h0, {1'b1, 32'h0});
		d = 8'($random(seed));
		b = 8'($random(seed));
		wr(SADR, d);
		wr(SMSK, b);
		rd(SADR, d);
		rd(SMSK, b);
		wr(PWR, 8'h80);
		wr(CTRL, 8'h58);
		tx(8'($random(seed)), 1'b1);
		rd(CTRL, 8'h5a);
		d = 8'($random(seed));
		u_serial_peer.send(d, 1'b1, 1'b1);
		rd(BUFA, d);
		rd(CTRL, 8'h5f);
		u_serial_peer.send(~d, 1'b0, 1'b1);
		rd(BUFA, d);
		rd(CTRL, 8'h5f);
		wr(CTRL, 8'h5c);
		d = 8'($random(seed));
		u_serial_peer.send(d, 1'b0, 1'b0);
		wr(PWR, 8'hc0);
		rd(CTRL, 8'hd9);
		rd(BUFA, d);
		wr(CTRL, 8'hd8);
		u_serial_peer.send(8'($random(seed)), 1'b1, 1'b1);
		rd(CTRL, 8'hdd);
		wr(CTRL, 8'h5c);
		rd(CTRL, 8'h5c);
		wr(PWR, 8'h80);
		rd(CTRL, 8'h5c);
		wr(SADR, 8'ha4);
		wr(SMSK, 8'hfa);
		wr(CTRL, 8'h7c);
		r9 = 1'b1;
		for (int i = 0; i < 5; i++) begin
			{hit, n9, d} = MP_TAB[i];
			u_serial_peer.send(d, n9, 1'b1);
			if (hit) b = d;
			if (hit) r9 = n9;
			rd(BUFA, b);
			rd(CTRL, {5'h0f, r9, 1'b0, hit});
			wr(CTRL, {5'h0f, r9, 2'h0});
		end
		wr(CTRL, 8'hdc);
		tx(8'($random(seed)), 1'b1);
		d = 8'($random(seed));
		u_serial_peer.send(d, 1'b0, 1'b1);
		rd(BUFA, d);
		rd(CTRL, 8'hdb);
		give_verdict();
	end
endmodule
`default_nettype wire
